// *** rtl/timer_control_status_capture.v ***
// Timer control, status flags, counter, compares and capture registers behind APB
//
// Behaviour
// - Capture irq enable lets either capture flag request the timer interrupt.
// - Compare irq enable lets either compare flag request the timer interrupt.
// - Overflow irq enable lets the overflow flag request the timer interrupt.
// - Force bits read zero; writing one copies out level to pin, flag untouched.
// - Out level two is loaded into the compare two pin at a match.
// - Out level one is loaded into the compare one pin at a match.
// - Capture one triggers on rising edge when edge select is one, else falling.
// - Capture two triggers on falling edges only.
// - Status is read-only with five flags at bits 7 down to 3.
// - Flags clear by status read, then access of the flag's data register.
// - Capture one flag sets on edge; cleared by status then capture one low read.
// - Compare one flag sets on match; cleared by status then compare one low access.
// - Overflow flag sets on wrap; cleared by status then counter low read.
// - Capture two flag sets on falling edge; cleared via capture two low read.
// - Compare two flag sets on match; cleared via compare two low access.
// - Capture one register latches the counter; high and low bytes.
// - Captured value is one more than the counter before the transition.
// - Capture happens on every edge not blocked by a high byte read, whether the flag is set or not.
// - Reading capture one high blocks transfers until the low byte is read.
// - Reading only capture one low does not block transfers.
// - Reset leaves the capture registers unchanged.
// - Counter advances once every four bus clocks.
// - Counter resets to FFFC; a write to counter low (or the alternate low) reloads FFFC.
`timescale 1ns/1ps
`include "timer_consts.vh"
module timer_control_status_capture
(
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Pins
	input wire capture_one_pin,
	input wire capture_two_pin,
	output reg compare_one_pin,
	output reg compare_two_pin,
	// Interrupt request
	output reg timer_irq
);
	reg [7:0] timer_control;
	reg [4:0] flags;
	reg [4:0] armed;
	reg [15:0] counter;
	reg [1:0] prescale;
	reg [15:0] capture_one_register;
	reg [15:0] capture_two_register;
	reg [15:0] compare_one;
	reg [15:0] compare_two;
	reg capture_one_block;
	reg capture_two_block;
	reg compare_one_block;
	reg compare_two_block;
	reg [7:0] counter_buffer;
	reg counter_buffered;
	reg [4:0] next_flags;
	reg [31:0] next_rdata;
	reg next_slverr;
	wire [9:0] idx;
	wire aligned;
	wire acc;
	wire rd;
	wire wr;
	wire tick;
	wire wrap;
	wire capture_one_edge;
	wire capture_two_edge;
	wire match_one;
	wire match_two;
	wire [4:0] event_set;
	wire [4:0] data_access;
	wire [7:0] status_byte;
	wire status_setup;

	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'h0) && (idx[9:8] == 2'h0);
	// Access phase completes in the first access cycle (pready high)
	assign acc = psel & penable & pready;
	assign rd = acc & ~pwrite;
	assign wr = acc & pwrite;
	// Arm from the same flag values that the status read returns
	assign status_setup = psel & ~penable & ~pwrite & aligned & (idx[7:0] == `IDX_TIMER_STATUS);
	assign tick = (prescale == `PRESCALE_LAST);
	assign wrap = tick & (counter == 16'hFFFF);

	edge_detect u_edge_one
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(capture_one_pin),
		.rising_sel(timer_control[`CTL_CAPTURE_ONE_EDGE_SELECT]),
		.edge_seen(capture_one_edge)
	);

	edge_detect u_edge_two
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(capture_two_pin),
		.rising_sel(1'b0),
		.edge_seen(capture_two_edge)
	);

	// Compare is checked once per count, suppressed while a high byte write is pending
	assign match_one = tick & ~compare_one_block & (compare_one == counter + 16'h0001);
	assign match_two = tick & ~compare_two_block & (compare_two == counter + 16'h0001);

	assign event_set[`FLAG_CAPTURE_ONE] = capture_one_edge;
	assign event_set[`FLAG_COMPARE_ONE] = match_one;
	assign event_set[`FLAG_OVERFLOW] = wrap;
	assign event_set[`FLAG_CAPTURE_TWO] = capture_two_edge;
	assign event_set[`FLAG_COMPARE_TWO] = match_two;

	assign data_access[`FLAG_CAPTURE_ONE] = rd && idx[7:0] == `IDX_CAPTURE_ONE_LOW;
	assign data_access[`FLAG_COMPARE_ONE] = acc && idx[7:0] == `IDX_COMPARE_ONE_LOW;
	assign data_access[`FLAG_OVERFLOW] = rd && idx[7:0] == `IDX_COUNTER_LOW;
	assign data_access[`FLAG_CAPTURE_TWO] = rd && idx[7:0] == `IDX_CAPTURE_TWO_LOW;
	assign data_access[`FLAG_COMPARE_TWO] = acc && idx[7:0] == `IDX_COMPARE_TWO_LOW;

	assign status_byte = {flags[`FLAG_CAPTURE_ONE], flags[`FLAG_COMPARE_ONE],
		flags[`FLAG_OVERFLOW], flags[`FLAG_CAPTURE_TWO], flags[`FLAG_COMPARE_TWO], 3'h0};

	// Flag update: set wins over a clear in the same cycle
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1)
		begin : g_flag
			always @*
			begin
				next_flags[g] = flags[g];
				if (aligned && data_access[g] && armed[g])
					next_flags[g] = 1'b0;
				if (event_set[g])
					next_flags[g] = 1'b1;
			end
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					armed[g] <= 1'b0;
				else if (event_set[g])
					armed[g] <= 1'b0;
				else if (status_setup)
					armed[g] <= flags[g];
				else if (aligned && data_access[g])
					armed[g] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags <= 5'h00;
		else
			flags <= next_flags;
	end

	// Prescaler and counter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale <= 2'h0;
			counter <= `COUNTER_RESET;
		end
		else if (wr && aligned && (idx[7:0] == `IDX_COUNTER_LOW || idx[7:0] == `IDX_ALT_COUNTER_LOW))
		begin
			prescale <= 2'h0;
			counter <= `COUNTER_RESET;
		end
		else
		begin
			prescale <= prescale + 2'h1;
			if (tick)
				counter <= counter + 16'h0001;
		end
	end

	// Capture registers have no reset
	always @(posedge pclk)
	begin
		if (capture_one_edge && !capture_one_block)
			capture_one_register <= counter + 16'h0001;
		if (capture_two_edge && !capture_two_block)
			capture_two_register <= counter + 16'h0001;
	end

	// Compare registers are storage with no reset
	always @(posedge pclk)
	begin
		if (wr && aligned)
		begin
			if (idx[7:0] == `IDX_COMPARE_ONE_HIGH)
				compare_one[15:8] <= pwdata[7:0];
			if (idx[7:0] == `IDX_COMPARE_ONE_LOW)
				compare_one[7:0] <= pwdata[7:0];
			if (idx[7:0] == `IDX_COMPARE_TWO_HIGH)
				compare_two[15:8] <= pwdata[7:0];
			if (idx[7:0] == `IDX_COMPARE_TWO_LOW)
				compare_two[7:0] <= pwdata[7:0];
		end
	end

	// High byte interlocks
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			capture_one_block <= 1'b0;
			capture_two_block <= 1'b0;
			compare_one_block <= 1'b0;
			compare_two_block <= 1'b0;
			counter_buffered <= 1'b0;
			counter_buffer <= 8'h00;
		end
		else if (acc && aligned)
		begin
			if (rd && idx[7:0] == `IDX_CAPTURE_ONE_HIGH)
				capture_one_block <= 1'b1;
			if (rd && idx[7:0] == `IDX_CAPTURE_ONE_LOW)
				capture_one_block <= 1'b0;
			if (rd && idx[7:0] == `IDX_CAPTURE_TWO_HIGH)
				capture_two_block <= 1'b1;
			if (rd && idx[7:0] == `IDX_CAPTURE_TWO_LOW)
				capture_two_block <= 1'b0;
			if (wr && idx[7:0] == `IDX_COMPARE_ONE_HIGH)
				compare_one_block <= 1'b1;
			if (wr && idx[7:0] == `IDX_COMPARE_ONE_LOW)
				compare_one_block <= 1'b0;
			if (wr && idx[7:0] == `IDX_COMPARE_TWO_HIGH)
				compare_two_block <= 1'b1;
			if (wr && idx[7:0] == `IDX_COMPARE_TWO_LOW)
				compare_two_block <= 1'b0;
			if (rd && !counter_buffered &&
				(idx[7:0] == `IDX_COUNTER_HIGH || idx[7:0] == `IDX_ALT_COUNTER_HIGH))
			begin
				counter_buffered <= 1'b1;
				counter_buffer <= counter[7:0];
			end
			if (idx[7:0] == `IDX_COUNTER_LOW || idx[7:0] == `IDX_ALT_COUNTER_LOW)
				counter_buffered <= 1'b0;
		end
	end

	// Control register and compare pins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_control <= `CONTROL_RESET;
			compare_one_pin <= 1'b0;
			compare_two_pin <= 1'b0;
		end
		else
		begin
			if (wr && aligned && idx[7:0] == `IDX_TIMER_CONTROL)
			begin
				// Force bits are never stored
				timer_control <= pwdata[7:0] & 8'hE7;
				if (pwdata[`CTL_FORCE_COMPARE_ONE])
					compare_one_pin <= pwdata[`CTL_OUT_LEVEL_ONE];
				if (pwdata[`CTL_FORCE_COMPARE_TWO])
					compare_two_pin <= pwdata[`CTL_OUT_LEVEL_TWO];
			end
			if (match_one)
				compare_one_pin <= timer_control[`CTL_OUT_LEVEL_ONE];
			if (match_two)
				compare_two_pin <= timer_control[`CTL_OUT_LEVEL_TWO];
		end
	end

	// Interrupt request
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= (timer_control[`CTL_CAPTURE_IRQ_ENABLE] &
				(next_flags[`FLAG_CAPTURE_ONE] | next_flags[`FLAG_CAPTURE_TWO])) |
				(timer_control[`CTL_COMPARE_IRQ_ENABLE] &
				(next_flags[`FLAG_COMPARE_ONE] | next_flags[`FLAG_COMPARE_TWO])) |
				(timer_control[`CTL_OVERFLOW_IRQ_ENABLE] & next_flags[`FLAG_OVERFLOW]);
	end

	// Read mux
	always @*
	begin
		next_rdata = 32'h0000_0000;
		next_slverr = 1'b0;
		if (!aligned)
			next_slverr = 1'b1;
		else
		begin
			case (idx[7:0])
				`IDX_TIMER_CONTROL: next_rdata[7:0] = timer_control;
				`IDX_TIMER_STATUS: next_rdata[7:0] = status_byte;
				`IDX_CAPTURE_ONE_HIGH: next_rdata[7:0] = capture_one_register[15:8];
				`IDX_CAPTURE_ONE_LOW: next_rdata[7:0] = capture_one_register[7:0];
				`IDX_COMPARE_ONE_HIGH: next_rdata[7:0] = compare_one[15:8];
				`IDX_COMPARE_ONE_LOW: next_rdata[7:0] = compare_one[7:0];
				`IDX_COUNTER_HIGH: next_rdata[7:0] = counter[15:8];
				`IDX_ALT_COUNTER_HIGH: next_rdata[7:0] = counter[15:8];
				`IDX_COUNTER_LOW: next_rdata[7:0] = counter_buffered ? counter_buffer : counter[7:0];
				`IDX_ALT_COUNTER_LOW: next_rdata[7:0] = counter_buffered ? counter_buffer : counter[7:0];
				`IDX_CAPTURE_TWO_HIGH: next_rdata[7:0] = capture_two_register[15:8];
				`IDX_CAPTURE_TWO_LOW: next_rdata[7:0] = capture_two_register[7:0];
				`IDX_COMPARE_TWO_HIGH: next_rdata[7:0] = compare_two[15:8];
				`IDX_COMPARE_TWO_LOW: next_rdata[7:0] = compare_two[7:0];
				default: next_slverr = 1'b1;
			endcase
		end
	end

	// APB answer: pready rises in the access phase, one cycle after setup
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= next_slverr;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // timer_control_status_capture

// *** rtl/timer_consts.vh ***
// Register offsets, bit positions, reset values and timing counts of the timer block
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// Printed register indices; byte address is four times the index
`define IDX_TIMER_CONTROL 8'h12
`define IDX_TIMER_STATUS 8'h13
`define IDX_CAPTURE_ONE_HIGH 8'h14
`define IDX_CAPTURE_ONE_LOW 8'h15
`define IDX_COMPARE_ONE_HIGH 8'h16
`define IDX_COMPARE_ONE_LOW 8'h17
`define IDX_COUNTER_HIGH 8'h18
`define IDX_COUNTER_LOW 8'h19
`define IDX_ALT_COUNTER_HIGH 8'h1A
`define IDX_ALT_COUNTER_LOW 8'h1B
`define IDX_CAPTURE_TWO_HIGH 8'h1C
`define IDX_CAPTURE_TWO_LOW 8'h1D
`define IDX_COMPARE_TWO_HIGH 8'h1E
`define IDX_COMPARE_TWO_LOW 8'h1F
// Control bit positions
`define CTL_CAPTURE_IRQ_ENABLE 7
`define CTL_COMPARE_IRQ_ENABLE 6
`define CTL_OVERFLOW_IRQ_ENABLE 5
`define CTL_FORCE_COMPARE_TWO 4
`define CTL_FORCE_COMPARE_ONE 3
`define CTL_OUT_LEVEL_TWO 2
`define CTL_CAPTURE_ONE_EDGE_SELECT 1
`define CTL_OUT_LEVEL_ONE 0
// Status bit positions
`define STS_CAPTURE_ONE_FLAG 7
`define STS_COMPARE_ONE_FLAG 6
`define STS_OVERFLOW_FLAG 5
`define STS_CAPTURE_TWO_FLAG 4
`define STS_COMPARE_TWO_FLAG 3
// Flag index in the internal flag vector
`define FLAG_COMPARE_TWO 0
`define FLAG_CAPTURE_TWO 1
`define FLAG_OVERFLOW 2
`define FLAG_COMPARE_ONE 3
`define FLAG_CAPTURE_ONE 4
// Reset values
`define CONTROL_RESET 8'h00
`define COUNTER_RESET 16'hFFFC
// Prescaler: counter advances once every this many bus clocks
`define PRESCALE_CYCLES 4
`define PRESCALE_LAST 2'h3
`endif

// *** rtl/edge_detect.v ***
// Edge detector for one capture pin with selectable polarity
`timescale 1ns/1ps
module edge_detect
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Pin and polarity
	input wire pin,
	input wire rising_sel,
	// Event
	output wire edge_seen
);
	reg last;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last <= 1'b1;
		else
			last <= pin;
	end
	assign edge_seen = rising_sel ? (pin & ~last) : (~pin & last);
endmodule // edge_detect

// *** verification/timer_control_status_capture_monitor.sv ***
// Bus protocol and register read-back checks on the timer block ports
`timescale 1ns/1ps
module timer_monitor
(
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Compare pins
	input wire compare_one_pin,
	input wire compare_two_pin
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire rd_done = pready && !pwrite;
	wire ctl_wr = psel && penable && pready && pwrite && paddr == 12'h048;
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_status_low: assert property (rd_done && paddr == 12'h04C |-> prdata[2:0] == 3'h0)
		else $error("unused status bits set");
	a_force_read: assert property (rd_done && paddr == 12'h048 |-> prdata[4:3] == 2'h0)
		else $error("force bits read back");
	a_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
		else $error("misaligned access accepted");
	a_force_one: assert property (ctl_wr && pwdata[3] |=> compare_one_pin == $past(pwdata[0]))
		else $error("force one pin wrong");
	a_force_two: assert property (ctl_wr && pwdata[4] |=> compare_two_pin == $past(pwdata[2]))
		else $error("force two pin wrong");
endmodule // timer_monitor

bind timer_control_status_capture timer_monitor i_mon(.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.compare_one_pin(compare_one_pin), .compare_two_pin(compare_two_pin));

// *** verification/capture_source.sv ***
// Drives the two capture inputs, one bus clock after the bench asks
`timescale 1ns/1ps
module capture_source
(
	// Clock
	input wire pclk,
	// Requested levels
	input wire level_one,
	input wire level_two,
	// Capture pins
	output reg capture_one_pin,
	output reg capture_two_pin
);
	initial
	begin
		capture_one_pin = 1'h1;
		capture_two_pin = 1'h1;
	end
	// Pins change only just after a clock edge, as a synchronous source
	always @(posedge pclk)
	begin
		capture_one_pin <= level_one;
		capture_two_pin <= level_two;
	end
endmodule // capture_source

// *** verification/timer_control_status_capture_tb.sv ***
// Self-checking bench for the timer control, status and capture block
`timescale 1ns/1ps
module timer_control_status_capture_tb;
	reg pclk = 0;
	reg presetn = 0;
	reg psel = 0, penable = 0, pwrite = 0, lv1 = 1, lv2 = 1;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0;
	wire [31:0] prdata;
	wire pready, pslverr, c1, c2, cmp1, cmp2, irq;
	int num_errors = 0, checks_done = 0, cyc = 0, k;
	reg [7:0] rd, r;
	reg er, p1, p2;
	reg [15:0] v1, v2;
	reg [31:0] seed = 32'h3DC4;
	always #25 pclk = ~pclk;
	capture_source i_src(.pclk(pclk), .level_one(lv1), .level_two(lv2),
		.capture_one_pin(c1), .capture_two_pin(c2));
	timer_control_status_capture i_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_one_pin(c1),
		.capture_two_pin(c2), .compare_one_pin(cmp1), .compare_two_pin(cmp2),
		.timer_irq(irq));
	task test_done;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string s, input [15:0] seen, input [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task apb(input w, input [11:0] a, input [7:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdc(input [11:0] a, input string s, input [7:0] exp);
		apb(0, a, 8'h00);
		chk(s, rd, exp);
	endtask
	task cap;
		apb(0, 12'h050, 8'h00);
		v2[15:8] = rd;
		apb(0, 12'h054, 8'h00);
		v2[7:0] = rd;
	endtask
	task wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	function [31:0] xs(input [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done;
		end
	end
	initial
	begin
		wt(8);
		presetn <= 1;
		// Compares at 0040 and 0080, high byte first
		apb(1, 12'h058, 8'h00);
		apb(1, 12'h05C, 8'h40);
		apb(1, 12'h078, 8'h00);
		apb(1, 12'h07C, 8'h80);
		rdc(12'h048, "ctl", 8'h00);
		apb(1, 12'h048, 8'h05);
		wt(600);
		rdc(12'h04C, "sts", 8'h68);
		chk("pin1", cmp1, 1'h1);
		chk("pin2", cmp2, 1'h1);
		p1 = 1;
		p2 = 1;
		for (k = 0; k < 24; k++)
		begin
			seed = xs(seed);
			r = seed[7:0];
			apb(1, 12'h048, r);
			wt(2);
			chk("irq", irq, r[6] | r[5]);
			if (r[3])
				p1 = r[0];
			if (r[4])
				p2 = r[2];
			chk("pin1", cmp1, p1);
			chk("pin2", cmp2, p2);
			rdc(12'h048, "ctl", r & 8'hE7);
		end
		// Alternate counter read must leave the overflow flag alone
		apb(0, 12'h06C, 8'h00);
		rdc(12'h04C, "sts", 8'h68);
		apb(0, 12'h064, 8'h00);
		apb(0, 12'h05C, 8'h00);
		apb(1, 12'h07C, 8'h80);
		rdc(12'h04C, "sts", 8'h00);
		apb(1, 12'h048, 8'h82);
		lv1 <= 0;
		wt(4);
		rdc(12'h04C, "sts", 8'h00);
		k = cyc;
		lv1 <= 1;
		wt(4);
		chk("irq", irq, 1'h1);
		cap;
		v1 = v2;
		rdc(12'h04C, "sts", 8'h80);
		apb(1, 12'h048, 8'h02);
		wt(2);
		chk("irq", irq, 1'h0);
		lv1 <= 0;
		while (cyc < k + 160) @(posedge pclk);
		lv1 <= 1;
		wt(4);
		apb(0, 12'h050, 8'h00);
		v2[15:8] = rd;
		// Edge while the high byte is held must not reach the register
		lv1 <= 0;
		wt(2);
		lv1 <= 1;
		wt(4);
		apb(0, 12'h054, 8'h00);
		v2[7:0] = rd;
		chk("cap", v2 - v1, 16'h0028);
		apb(0, 12'h054, 8'h00);
		lv1 <= 0;
		while (cyc < k + 320) @(posedge pclk);
		lv1 <= 1;
		wt(4);
		cap;
		chk("cap", v2 - v1, 16'h0050);
		rdc(12'h04C, "sts", 8'h80);
		apb(0, 12'h054, 8'h00);
		rdc(12'h04C, "sts", 8'h00);
		lv2 <= 0;
		wt(4);
		rdc(12'h04C, "sts", 8'h10);
		lv2 <= 1;
		wt(4);
		lv2 <= 0;
		wt(4);
		apb(0, 12'h074, 8'h00);
		rdc(12'h04C, "sts", 8'h10);
		apb(0, 12'h074, 8'h00);
		rdc(12'h04C, "sts", 8'h00);
		lv2 <= 1;
		wt(4);
		rdc(12'h04C, "sts", 8'h00);
		apb(0, 12'h04D, 8'h00);
		chk("err", er, 1'h1);
		apb(0, 12'h000, 8'h00);
		chk("err", er, 1'h1);
		chk("rdata", rd, 8'h00);
		// Mid-run reset: counter reloads, capture register keeps its value
		v1 = v2;
		presetn <= 0;
		wt(2);
		presetn <= 1;
		rdc(12'h060, "cnt", 8'hFF);
		rdc(12'h064, "cnt", 8'hFC);
		cap;
		chk("cap", v2, v1);
		test_done;
	end
endmodule // timer_control_status_capture_tb
